/* hw/bccc_pkg.sv */
/*
 Package for the charger command controller: command codes, alarm word
 fields, clamp constants and controller states.
 Assumes a decoded SMBus slave sub-block upstream.
*/
package bccc_pkg;
	// Decoded command codes from the SMBus interface sub-block
	localparam logic [7:0]  CMD_CHARGE_CURRENT = 8'h14;
	localparam logic [7:0]  CMD_CHARGE_VOLTAGE = 8'h15;
	localparam logic [7:0]  CMD_ALARM_WARNING  = 8'h16;
	localparam logic [7:0]  CMD_VERSION        = 8'h3C;
	// Version word, value arbitrary
	localparam logic [15:0] VERSION_CODE       = 16'h0A5C;
	// Alarm word fields
	localparam int          ALARM_STOP_MSB     = 15;
	localparam int          ALARM_STOP_LSB     = 12;
	localparam int          DISCHARGE_END_BIT  = 11;
	localparam int          INFO_MSB           = 10;
	localparam int          INFO_LSB           = 4;
	// Reset values and limits
	localparam logic [15:0] TARGET_RESET       = 16'h0000;
	localparam logic [15:0] ALL_ONES           = 16'hFFFF;
	localparam logic [15:0] CURRENT_LIMIT      = 16'h0FA0;
	localparam logic [15:0] CURRENT_SAFE_MAX   = 16'h1F40;
	localparam logic [15:0] VOLTAGE_LIMIT      = 16'h3390;
	localparam logic [15:0] VOLTAGE_SAFE_MAX   = 16'h3390;

	typedef enum logic [1:0] {
		BCCC_IDLE       = 2'b00,
		BCCC_AUTONOMOUS = 2'b01,
		BCCC_CONTROLLED = 2'b10,
		BCCC_NO_CHARGE  = 2'b11
	} bccc_state_t;
endpackage

/* hw/bccc_ctrl.sv */
/*
 Charger command controller: takes decoded SMBus slave commands, sets
 charge targets, acts on alarm words, answers the version query and
 requests host attention.
 Assumes a same-clock SMBus interface sub-block giving one-cycle strobes.
*/
`timescale 1ns/1ps
`default_nettype none
module bccc_ctrl
	import bccc_pkg::*;
(
	// Clock and reset
	input  wire logic        clock_in,
	input  wire logic        reset_n_in,
	// Decoded command port
	input  wire logic        cmd_write_in,
	input  wire logic        cmd_read_in,
	input  wire logic [7:0]  cmd_code_in,
	input  wire logic [15:0] cmd_data_in,
	input  wire logic        host_mode_in,
	input  wire logic        battery_present_in,
	output var  logic        cmd_ack_out,
	output var  logic        cmd_nack_out,
	output var  logic [15:0] cmd_rdata_out,
	// Charger targets and status
	output var  logic [15:0] charge_voltage_cmd_out,
	output var  logic [15:0] charge_current_cmd_out,
	output var  logic        charge_enable_out,
	output var  logic [1:0]  charge_state_out,
	output var  logic        host_attention_n_out
);

	bccc_state_t state;
	bccc_state_t next_state;
	logic        stop_alarm;
	logic        is_write_cmd;
	logic        is_alarm;
	logic        got_voltage;
	logic        got_current;
	logic        attention_pending;

	function automatic logic [15:0] clamp_word(input logic [15:0] req,
		input logic [15:0] limit, input logic [15:0] safe_max);
		if (req == ALL_ONES) begin
			clamp_word = safe_max;
		end else if (req > limit) begin
			clamp_word = limit;
		end else begin
			clamp_word = req;
		end
	endfunction

	assign is_alarm     = cmd_write_in && (cmd_code_in == CMD_ALARM_WARNING);
	assign stop_alarm   = is_alarm && (|cmd_data_in[ALARM_STOP_MSB:ALARM_STOP_LSB]);
	assign is_write_cmd = (cmd_code_in == CMD_CHARGE_CURRENT)
		|| (cmd_code_in == CMD_CHARGE_VOLTAGE) || (cmd_code_in == CMD_ALARM_WARNING);

	// Command answers
	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			cmd_ack_out   <= 1'b0;
			cmd_nack_out  <= 1'b0;
			cmd_rdata_out <= 16'h0000;
		end else begin
			cmd_ack_out   <= 1'b0;
			cmd_nack_out  <= 1'b0;
			if (cmd_read_in) begin
				if (cmd_code_in == CMD_VERSION) begin
					cmd_ack_out   <= 1'b1;
					cmd_rdata_out <= VERSION_CODE;
				end else begin
					cmd_nack_out <= 1'b1;
				end
			end else if (cmd_write_in) begin
				if (is_write_cmd) begin
					cmd_ack_out <= 1'b1;
				end else begin
					cmd_nack_out <= 1'b1;
				end
			end
		end
	end

	// Targets, same path for battery and host sources
	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			charge_voltage_cmd_out <= TARGET_RESET;
			charge_current_cmd_out <= TARGET_RESET;
		end else if (cmd_write_in) begin
			if (cmd_code_in == CMD_CHARGE_VOLTAGE) begin
				charge_voltage_cmd_out <= clamp_word(cmd_data_in, VOLTAGE_LIMIT,
					VOLTAGE_SAFE_MAX);
			end else if (cmd_code_in == CMD_CHARGE_CURRENT) begin
				charge_current_cmd_out <= clamp_word(cmd_data_in, CURRENT_LIMIT,
					CURRENT_SAFE_MAX);
			end
		end
	end

	// Pair tracking for controlled charge
	always_ff @(posedge clock_in) begin
		if (!reset_n_in || stop_alarm || state == BCCC_CONTROLLED) begin
			got_voltage <= 1'b0;
			got_current <= 1'b0;
		end else if (cmd_write_in) begin
			if (cmd_code_in == CMD_CHARGE_VOLTAGE) begin
				got_voltage <= 1'b1;
			end
			if (cmd_code_in == CMD_CHARGE_CURRENT) begin
				got_current <= 1'b1;
			end
		end
	end

	always_comb begin
		next_state = state;
		case (state)
			BCCC_IDLE: begin
				if (battery_present_in) begin
					next_state = BCCC_AUTONOMOUS;
				end
			end
			BCCC_AUTONOMOUS, BCCC_NO_CHARGE: begin
				if (got_voltage && got_current) begin
					next_state = BCCC_CONTROLLED;
				end
			end
			BCCC_CONTROLLED: begin
				next_state = BCCC_CONTROLLED;
			end
			default: begin
				next_state = BCCC_IDLE;
			end
		endcase
		if (stop_alarm && state != BCCC_IDLE) begin
			next_state = BCCC_NO_CHARGE;
		end
	end

	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			state <= BCCC_IDLE;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			charge_enable_out <= 1'b0;
			charge_state_out  <= 2'b00;
		end else begin
			charge_enable_out <= (next_state == BCCC_AUTONOMOUS)
				|| (next_state == BCCC_CONTROLLED);
			charge_state_out  <= next_state;
		end
	end

	// Host attention on state change, cleared by a host poll
	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			attention_pending <= 1'b0;
		end else if (next_state != state) begin
			attention_pending <= 1'b1;
		end else if (cmd_read_in && host_mode_in) begin
			attention_pending <= 1'b0;
		end
	end

	always_ff @(posedge clock_in) begin
		if (!reset_n_in) begin
			host_attention_n_out <= 1'b1;
		end else begin
			host_attention_n_out <= !(attention_pending || (next_state != state));
		end
	end

	sequence s_alarm_stop;
		stop_alarm && state != BCCC_IDLE;
	endsequence

	a_alarm_stops_charge:
	assert property (@(posedge clock_in) disable iff (!reset_n_in)
		s_alarm_stop |=> state == BCCC_NO_CHARGE ##0 !charge_enable_out[*1] ##1 1'b1)
	else $error("alarm did not stop charge");
	a_version_answer:
	assert property (@(posedge clock_in) disable iff (!reset_n_in)
		cmd_read_in && cmd_code_in == CMD_VERSION |=> cmd_ack_out && cmd_rdata_out == VERSION_CODE)
	else $error("version answer wrong");
	a_alarm_read_nack:
	assert property (@(posedge clock_in) disable iff (!reset_n_in)
		cmd_read_in && cmd_code_in == CMD_ALARM_WARNING |=> cmd_nack_out && !cmd_ack_out)
	else $error("alarm read not refused");
	a_info_no_effect:
	assert property (@(posedge clock_in) disable iff (!reset_n_in)
		is_alarm && !stop_alarm && !cmd_read_in |=> cmd_ack_out
		&& (state != BCCC_NO_CHARGE || $past(state) == BCCC_NO_CHARGE)
		&& charge_current_cmd_out == $past(charge_current_cmd_out))
	else $error("info alarm bits had effect");
	a_current_clamp:
	assert property (@(posedge clock_in) disable iff (!reset_n_in)
		cmd_write_in && cmd_code_in == CMD_CHARGE_CURRENT && cmd_data_in == ALL_ONES
		|=> charge_current_cmd_out == CURRENT_SAFE_MAX)
	else $error("current safe max not applied");
	a_current_limit:
	assert property (@(posedge clock_in) disable iff (!reset_n_in)
		##1 charge_current_cmd_out <= CURRENT_LIMIT || charge_current_cmd_out == CURRENT_SAFE_MAX)
	else $error("current above limit");
	a_voltage_target:
	assert property (@(posedge clock_in) disable iff (!reset_n_in)
		cmd_write_in && cmd_code_in == CMD_CHARGE_VOLTAGE && cmd_data_in <= VOLTAGE_LIMIT
		|=> charge_voltage_cmd_out == $past(cmd_data_in))
	else $error("voltage target not taken");
	a_attention_low:
	assert property (@(posedge clock_in) disable iff (!reset_n_in)
		next_state != state |=> !host_attention_n_out)
	else $error("attention not asserted");

endmodule
`default_nettype wire

/* tb/bccc_host_model.sv */
/*
 Host-side model: issues decoded command strobes toward the controller.
 Assumes the controller answers ack or nack one cycle after a strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module bccc_host_model
	import bccc_pkg::*;
(
	// Clock and answers
	input  wire logic        clock_in,
	input  wire logic        cmd_ack_in,
	input  wire logic        cmd_nack_in,
	// Command drive
	output var  logic        cmd_write_out,
	output var  logic        cmd_read_out,
	output var  logic [7:0]  cmd_code_out,
	output var  logic [15:0] cmd_data_out,
	output var  logic        host_mode_out,
	output var  logic        battery_present_out
);
	initial begin
		{cmd_write_out, cmd_read_out, host_mode_out, battery_present_out} = 4'h0;
		cmd_code_out = 8'h00;
		cmd_data_out = 16'h0000;
	end
	// One strobe, then bounded wait for the answer; host acts as master
	task automatic xfer(input logic rd, input logic [7:0] c, input logic [15:0] d,
			output logic a, output logic n, output logic got);
		got = 1'b0;
		@(posedge clock_in);
		#1;
		cmd_read_out = rd;
		cmd_write_out = !rd;
		cmd_code_out = c;
		// Error nibble set high on alarm words
		cmd_data_out = (c == CMD_ALARM_WARNING) ? (d | 16'h000F) : d;
		@(posedge clock_in);
		#1;
		cmd_read_out = 1'b0;
		cmd_write_out = 1'b0;
		cmd_code_out = ~c;
		cmd_data_out = ~cmd_data_out;
		for (int i = 0; i < 4 && !got; i++) begin
			if (cmd_ack_in || cmd_nack_in) begin
				a = cmd_ack_in;
				n = cmd_nack_in;
				got = 1'b1;
			end else begin
				@(posedge clock_in);
				#1;
			end
		end
	endtask
endmodule
`default_nettype wire

/* tb/test_battery_charger_smbus_command_control.sv */
/*
 Testbench for the charger command controller.
 Assumes the host model drives the command port.
*/
`timescale 1ns/1ps
`default_nettype none
module test_battery_charger_smbus_command_control;
	import bccc_pkg::*;
	logic clock_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic wr, rd, hm, bp, ack, nack, en, att_n;
	logic [7:0] code;
	logic [15:0] data, rdata, volt, curr;
	logic [1:0] st;
	int failures = 0;
	int n_compared = 0;
	always #10 clock_in = ~clock_in;
	bccc_host_model i_host (.clock_in(clock_in), .cmd_ack_in(ack), .cmd_nack_in(nack),
		.cmd_write_out(wr), .cmd_read_out(rd), .cmd_code_out(code), .cmd_data_out(data),
		.host_mode_out(hm), .battery_present_out(bp));
	bccc_ctrl i_dut (.clock_in(clock_in), .reset_n_in(reset_n_in), .cmd_write_in(wr),
		.cmd_read_in(rd), .cmd_code_in(code), .cmd_data_in(data), .host_mode_in(hm),
		.battery_present_in(bp), .cmd_ack_out(ack), .cmd_nack_out(nack),
		.cmd_rdata_out(rdata), .charge_voltage_cmd_out(volt),
		.charge_current_cmd_out(curr), .charge_enable_out(en),
		.charge_state_out(st), .host_attention_n_out(att_n));
	task automatic close_out();
		$display("failures=%0d n_compared=%0d", failures, n_compared);
		if (failures == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Command with expected answer: 2 ack, 1 nack
	task automatic cmd(input logic r, input logic [7:0] c, input logic [15:0] d,
			input logic [1:0] exp);
		logic a, n, got;
		i_host.xfer(r, c, d, a, n, got);
		if (!got) begin
			failures++;
			close_out();
		end
		chk({14'h0, a, n}, {14'h0, exp});
	endtask
	task automatic idle_refusals();
		chk(volt, TARGET_RESET);
		chk(curr, TARGET_RESET);
		chk({12'h000, st, en, att_n}, 16'h0001);
		cmd(1'b1, CMD_VERSION, 16'h0000, 2'h2);
		chk(rdata, VERSION_CODE);
		cmd(1'b0, CMD_VERSION, 16'h1234, 2'h1);
		cmd(1'b1, CMD_ALARM_WARNING, 16'h0000, 2'h1);
		cmd(1'b1, CMD_CHARGE_CURRENT, 16'h0000, 2'h1);
		cmd(1'b1, CMD_CHARGE_VOLTAGE, 16'h0000, 2'h1);
	endtask
	task automatic attention_poll();
		i_host.battery_present_out = 1'b1;
		repeat (3) @(posedge clock_in);
		#1;
		chk({12'h000, st, en, att_n}, 16'h0006);
		i_host.host_mode_out = 1'b1;
		cmd(1'b1, CMD_VERSION, 16'h0000, 2'h2);
		repeat (2) @(posedge clock_in);
		#1;
		chk({15'h0, att_n}, 16'h0001);
		cmd(1'b0, CMD_ALARM_WARNING, 16'h0FF0, 2'h2);
		chk({13'h0, st, en}, 16'h0003);
	endtask
	task automatic targets_and_stop();
		cmd(1'b0, CMD_CHARGE_CURRENT, 16'hFFFF, 2'h2);
		chk(curr, CURRENT_SAFE_MAX);
		cmd(1'b0, CMD_CHARGE_CURRENT, CURRENT_LIMIT + 16'h0001, 2'h2);
		chk(curr, CURRENT_LIMIT);
		cmd(1'b0, CMD_CHARGE_CURRENT, 16'h0100, 2'h2);
		chk(curr, 16'h0100);
		cmd(1'b0, CMD_CHARGE_VOLTAGE, 16'hFFFF, 2'h2);
		chk(volt, VOLTAGE_SAFE_MAX);
		// Pair seen at the ack edge, state moves one edge later
		@(posedge clock_in);
		#1;
		chk({13'h0, st, en}, 16'h0005);
		cmd(1'b0, CMD_ALARM_WARNING, 16'h8000, 2'h2);
		chk({12'h000, st, en, att_n}, 16'h000C);
	endtask
	// Mid-run reset clears targets, then battery restarts autonomous charge
	task automatic reset_again();
		reset_n_in = 1'b0;
		repeat (2) @(posedge clock_in);
		#1;
		chk(volt, TARGET_RESET);
		chk(curr, TARGET_RESET);
		chk({12'h000, st, en, att_n}, 16'h0001);
		reset_n_in = 1'b1;
		@(posedge clock_in);
		#1;
		chk({12'h000, st, en, att_n}, 16'h0006);
	endtask
	initial begin
		repeat (10) @(posedge clock_in);
		#1;
		reset_n_in = 1'b1;
		idle_refusals();
		attention_poll();
		targets_and_stop();
		reset_again();
		close_out();
	end
endmodule
`default_nettype wire
